// file: core/asrx_core.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - incoming bits are recovered by a x16 oversampling sampler
// - shift register advances once per bit, at the bit rate
// - frames accepted only while continuous receive enable, bit 4, is set
// - after stop bit word goes to fifo if room, then receive flag bit 5
// - interrupt request only when receive flag and enable bit 5 both set
// - receive flag read-only; cleared once data reads empty the fifo
// - receive data is a two-deep fifo, third word may shift meanwhile
// - fifo full at third stop bit sets overrun bit 1, word dropped
// - while overrun set, no transfers into the fifo
// - overrun cleared only by clearing then setting continuous receive enable
// - framing error bit 2 set when stop bit sampled low
// - framing error and ninth bit stored per entry, reloaded on each read
// - ninth bit enable captures a ninth bit shown in the status
// - address detect in nine-bit mode loads only address words
module asrx_core #(
  parameter int DEPTH = 2
) (
  input  wire logic        clk_i,   // 40 MHz clock
  input  wire logic        rst_i,   // sync reset, active high
  input  wire logic        cyc_i,   // wishbone cycle
  input  wire logic        stb_i,   // wishbone strobe
  input  wire logic        we_i,    // wishbone write
  input  wire logic [9:0]  adr_i,   // byte address
  input  wire logic [3:0]  sel_i,   // byte selects
  input  wire logic [31:0] dat_i,   // write data
  output logic      [31:0] dat_o,   // read data
  output logic             ack_o,   // wishbone ack
  input  wire logic        rx_i,    // serial receive line, idle high
  output logic             irq_o    // receive interrupt request
);
  initial begin
    if (DEPTH != 2) $error("fifo depth must be two");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } asrx_state_e;

  logic [7:0] intctl_q, pen_q, rxsc_q, txsc_q, baud_q;
  asrx_pkg::asrx_word_s fifo_q [DEPTH];
  logic [1:0]  count_q;
  logic        overrun_error_q;
  asrx_state_e state_q;
  logic [3:0]  sub_q;
  logic [3:0]  bit_q;
  logic [8:0]  shreg_q;
  logic        tick;
  logic        rx_q;
  logic        line_idle_q;

  wire       acc     = cyc_i && stb_i && !ack_o;
  wire [7:0] idx     = adr_i[9:2];
  wire       wr      = acc && we_i && sel_i[0];
  wire       rd_data = acc && !we_i && idx == asrx_pkg::OFF_RXDATA;
  wire       continuous_receive_enable    = rxsc_q[asrx_pkg::RXSC_CONTINUOUS_RECEIVE_ENABLE];
  wire       nine    = rxsc_q[asrx_pkg::RXSC_RX9];
  wire       run     = rxsc_q[asrx_pkg::RXSC_SERIAL_PORT_ENABLE] && !txsc_q[asrx_pkg::TX_SYNC] && continuous_receive_enable;
  wire       pop     = rd_data && count_q != 2'h0;

  // x16 tick source
  asrx_baud #(.DIV_W(8)) asrx_baud_inst (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .high_i (txsc_q[asrx_pkg::TX_HIGH_SPEED_BAUD_SELECT]),
    .div_i  (baud_q),
    .tick_o (tick)
  );

  // wishbone ack: one wait cycle, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else       ack_o <= acc;
  end

  // control registers; status bits are masked to hardware copies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intctl_q <= asrx_pkg::RST_INTCTL;
      pen_q    <= asrx_pkg::RST_PEN;
      rxsc_q   <= asrx_pkg::RST_RXSC;
      txsc_q   <= asrx_pkg::RST_TXSC;
      baud_q   <= asrx_pkg::RST_BAUD;
    end else if (wr) begin
      case (idx)
        asrx_pkg::OFF_INTCTL: intctl_q <= dat_i[7:0];
        asrx_pkg::OFF_PEN:    pen_q    <= dat_i[7:0];
        asrx_pkg::OFF_RXSC:   rxsc_q   <= {dat_i[7:3], 3'h0};
        asrx_pkg::OFF_TXSC:   txsc_q   <= {dat_i[7:2], 1'b1, dat_i[0]};
        asrx_pkg::OFF_BAUD:   baud_q   <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (acc && !we_i) begin
      case (idx)
        asrx_pkg::OFF_INTCTL: dat_o <= {24'h0, intctl_q};
        asrx_pkg::OFF_PFLAGS: dat_o <= {26'h0, count_q != 2'h0, 5'h0};
        asrx_pkg::OFF_RXSC:   dat_o <= {24'h0, rxsc_q[7:3], fifo_q[0].framing_error && count_q != 2'h0,
                                        overrun_error_q, fifo_q[0].ninth && count_q != 2'h0};
        asrx_pkg::OFF_RXDATA: dat_o <= {24'h0, count_q != 2'h0 ? fifo_q[0].data : 8'h00};
        asrx_pkg::OFF_PEN:    dat_o <= {24'h0, pen_q};
        asrx_pkg::OFF_TXSC:   dat_o <= {24'h0, txsc_q};
        asrx_pkg::OFF_BAUD:   dat_o <= {24'h0, baud_q};
        default:              dat_o <= 32'h0;
      endcase
    end
  end

  // line register; inputs are synchronous so one stage suffices
  always_ff @(posedge clk_i) begin
    if (rst_i) rx_q <= 1'b1;
    else       rx_q <= rx_i;
  end

  // frame end: stop sample taken this tick
  wire stop_now = tick && state_q == ST_STOP && sub_q == 4'(asrx_pkg::MID_SAMPLE);
  wire framing_error_now = !rx_q;
  asrx_pkg::asrx_word_s new_word;
  assign new_word = {framing_error_now, shreg_q[8], shreg_q[7:0]};
  // address word has ninth bit set
  wire is_addr  = shreg_q[8];
  // filter data words under address detect
  wire wanted   = !(nine && rxsc_q[asrx_pkg::RXSC_ADDRESS_DETECT_ENABLE]) || is_addr;
  // blocked while overrun
  // a read in the same cycle frees a slot, so a full fifo still takes the word
  wire push     = stop_now && wanted && !overrun_error_q && (count_q != 2'(DEPTH) || pop);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      state_q <= ST_IDLE;
      sub_q   <= 4'h0;
      bit_q   <= 4'h0;
      shreg_q <= 9'h0;
      line_idle_q <= 1'b0;
    end else if (tick) begin
      sub_q <= sub_q + 4'h1;
      case (state_q)
        ST_IDLE: begin
          sub_q <= 4'h0;
          // need the line high first, so a low stop bit is not taken as a new start
          if (rx_q) begin
            line_idle_q <= 1'b1;
          end else if (line_idle_q) begin
            state_q     <= ST_START;
            line_idle_q <= 1'b0;
          end
        end
        ST_START: begin
          if (sub_q == 4'(asrx_pkg::MID_SAMPLE)) begin
            if (rx_q) state_q <= ST_IDLE;
          end else if (sub_q == 4'(asrx_pkg::OVERSAMPLE - 1)) begin
            state_q <= ST_DATA;
            bit_q   <= 4'h0;
          end
        end
        ST_DATA: begin
          if (sub_q == 4'(asrx_pkg::MID_SAMPLE)) begin
            if (nine) shreg_q <= {rx_q, shreg_q[8:1]};
            else      shreg_q <= {1'b0, rx_q, shreg_q[7:1]};
          end else if (sub_q == 4'(asrx_pkg::OVERSAMPLE - 1)) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == (nine ? 4'h8 : 4'h7)) state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          // early return to idle keeps us aligned to the next start edge
          if (sub_q == 4'(asrx_pkg::MID_SAMPLE)) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !continuous_receive_enable) begin
      count_q <= 2'h0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end else begin
      if (pop) begin
        fifo_q[0] <= fifo_q[1];
      end
      // new word goes to the first slot left free after any pop
      if (push) begin
        if (count_q == 2'h0 || (pop && count_q == 2'h1)) fifo_q[0] <= new_word;
        else                                               fifo_q[1] <= new_word;
      end
      // flag clears when reads empty fifo
      count_q <= count_q + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !continuous_receive_enable) overrun_error_q <= 1'b0;
    else if (stop_now && wanted && count_q == 2'(DEPTH) && !pop) overrun_error_q <= 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else       irq_o <= (count_q != 2'h0) && pen_q[asrx_pkg::PE_RXIE];
  end

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i) irq_o |-> $past(count_q != 2'h0 && pen_q[asrx_pkg::PE_RXIE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

  property p_push_count;
    @(posedge clk_i) disable iff (rst_i) push && !pop && continuous_receive_enable |=> count_q == $past(count_q) + 2'h1;
  endproperty
  a_push_count: assert property (p_push_count) else $error("push did not grow fifo");

  property p_depth;
    @(posedge clk_i) disable iff (rst_i) count_q <= 2'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo over depth");

  property p_overrun_error_block;
    @(posedge clk_i) disable iff (rst_i) overrun_error_q |=> count_q <= $past(count_q);
  endproperty
  a_overrun_error_block: assert property (p_overrun_error_block) else $error("transfer during overrun");

  property p_overrun_error_clear;
    @(posedge clk_i) disable iff (rst_i) !continuous_receive_enable |=> !overrun_error_q;
  endproperty
  a_overrun_error_clear: assert property (p_overrun_error_clear) else $error("overrun survived receive reset");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i) !continuous_receive_enable |=> state_q == ST_IDLE && count_q == 2'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("receive active while disabled");

  sequence s_full_stop;
    stop_now && wanted && continuous_receive_enable && count_q == 2'h2 && !pop;
  endsequence

  property p_ovr_set;
    @(posedge clk_i) disable iff (rst_i)
      s_full_stop |=> overrun_error_q && count_q == 2'h2;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

  property p_filter;
    @(posedge clk_i) disable iff (rst_i) stop_now && nine && rxsc_q[asrx_pkg::RXSC_ADDRESS_DETECT_ENABLE] && !shreg_q[8] |-> !push;
  endproperty
  a_filter: assert property (p_filter) else $error("data word passed address filter");
endmodule : asrx_core

// file: shared/asrx_pkg.sv
package asrx_pkg;
  // register offsets (byte addresses are four times these indices)
  localparam logic [7:0] OFF_INTCTL = 8'h0b;
  localparam logic [7:0] OFF_PFLAGS = 8'h0c;
  localparam logic [7:0] OFF_RXSC   = 8'h18;
  localparam logic [7:0] OFF_RXDATA = 8'h1a;
  localparam logic [7:0] OFF_PEN    = 8'h8c;
  localparam logic [7:0] OFF_TXSC   = 8'h98;
  localparam logic [7:0] OFF_BAUD   = 8'h99;
  // receive status/control fields
  localparam int RXSC_SERIAL_PORT_ENABLE  = 7;
  localparam int RXSC_RX9   = 6;
  localparam int RXSC_SREN  = 5;
  localparam int RXSC_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RXSC_ADDRESS_DETECT_ENABLE = 3;
  localparam int RXSC_FRAMING_ERROR  = 2;
  localparam int RXSC_OVERRUN_ERROR  = 1;
  localparam int RXSC_R9D   = 0;
  // flag, enable and transmit status fields
  localparam int PF_RXFLAG  = 5;
  localparam int PE_RXIE    = 5;
  localparam int TX_SYNC    = 4;
  localparam int TX_HIGH_SPEED_BAUD_SELECT    = 2;
  // reset values
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic [7:0] RST_PEN    = 8'h00;
  localparam logic [7:0] RST_RXSC   = 8'h00;
  localparam logic [7:0] RST_TXSC   = 8'h02;
  localparam logic [7:0] RST_BAUD   = 8'h00;
  // timing
  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = 7;
  localparam int LOWSPD_PRE = 4;
  // one fifo entry: data, ninth bit, framing error
  typedef struct packed {
    logic       framing_error;
    logic       ninth;
    logic [7:0] data;
  } asrx_word_s;
endpackage : asrx_pkg

// file: core/asrx_baud.sv
`timescale 1ns/1ps
// x16 tick generator: divisor+1 clocks per tick, times 4 when low speed
module asrx_baud #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // sync reset
  input  wire logic             run_i,   // held in reset when low
  input  wire logic             high_i,  // high-speed range
  input  wire logic [DIV_W-1:0] div_i,   // divisor
  output logic                  tick_o   // x16 enable pulse
);
  initial begin
    if (DIV_W < 1) $error("DIV_W must be positive");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [1:0]       pre_q;

  // divisor counter and low-speed prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q  <= '0;
      pre_q  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (cnt_q >= div_i) begin
        cnt_q <= '0;
        pre_q <= pre_q + 2'h1;
        if (high_i || pre_q == 2'(asrx_pkg::LOWSPD_PRE - 1)) begin
          tick_o <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : asrx_baud

// file: bench/asrx_tx_model.sv
`timescale 1ns/1ps
// remote transmitter driving the idle-high receive line
module asrx_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_i,  // bench clock
  output logic      rx_o    // serial line into the receiver
);
  // line rests high between frames
  initial rx_o = 1'b1;

  // one frame; a low stop bit is a deliberate framing fault
  // start, lsb first
  // clks of zero keeps the default bit time
  task automatic send(input logic [8:0] w, input logic nine, input logic stop, input int clks);
    int n;
    int len;
    n = nine ? 9 : 8;
    len = (clks > 0) ? clks : BIT_CLKS;
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_o <= w[i];
      repeat (len) @(posedge clk_i);
    end
    rx_o <= stop;
    repeat (len) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (len) @(posedge clk_i);
  endtask : send
endmodule : asrx_tx_model

// file: bench/tb_async_serial_receiver.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_async_serial_receiver;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  wire logic   rx_i;
  logic        irq_o;
  int          errors;
  int          checks_done;
  int          bit_clks;
  logic [7:0]  offs [8];
  logic [7:0]  rsts [8];

  asrx_core asrx_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_i(rx_i), .irq_o(irq_o));
  // divisor 1, high speed: 2 clocks a tick, 32 a bit
  asrx_tx_model #(.BIT_CLKS(32)) asrx_tx_model_inst (.clk_i(clk_i), .rx_o(rx_i));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // classic single cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, wd};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    `CHK(d, {24'h000000, e})
  endtask : rd

  task automatic tx(input logic [8:0] w, input logic nine, input logic stop);
    asrx_tx_model_inst.send(w, nine, stop, bit_clks);
  endtask : tx

  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // hang guard, well past the roughly 5500 cycles the run needs
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 10'h000;
    sel_i = 4'h1;
    dat_i = 32'h00000000;
    errors = 0;
    checks_done = 0;
    bit_clks = 32;
    offs = '{8'h0b, 8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h00};
    rsts = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped index last
    for (int i = 0; i < 8; i++) rd(offs[i], rsts[i]);
    wr(asrx_pkg::OFF_INTCTL, 8'hc0);
    rd(asrx_pkg::OFF_INTCTL, 8'hc0);
    wr(asrx_pkg::OFF_BAUD, 8'h01);
    wr(asrx_pkg::OFF_TXSC, 8'h04);
    rd(asrx_pkg::OFF_TXSC, 8'h06);
    wr(asrx_pkg::OFF_PEN, 8'h20);
    wr(asrx_pkg::OFF_RXSC, 8'h80);
    tx(9'h055, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_PFLAGS, 8'h00);
    wr(asrx_pkg::OFF_RXSC, 8'h90);
    tx(9'h055, 1'b0, 1'b1);
    tx(9'h0a3, 1'b0, 1'b0);
    rd(asrx_pkg::OFF_PFLAGS, 8'h20);
    `CHK(irq_o, 1'b1)
    wr(asrx_pkg::OFF_PEN, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(asrx_pkg::OFF_PEN, 8'h20);
    rd(asrx_pkg::OFF_RXSC, 8'h90);
    rd(asrx_pkg::OFF_RXDATA, 8'h55);
    rd(asrx_pkg::OFF_RXSC, 8'h94);
    rd(asrx_pkg::OFF_RXDATA, 8'ha3);
    wr(asrx_pkg::OFF_PFLAGS, 8'hff);
    rd(asrx_pkg::OFF_PFLAGS, 8'h00);
    `CHK(irq_o, 1'b0)
    // third word with a full fifo is dropped and later ones blocked
    tx(9'h011, 1'b0, 1'b1);
    tx(9'h022, 1'b0, 1'b1);
    tx(9'h033, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_RXSC, 8'h92);
    rd(asrx_pkg::OFF_RXDATA, 8'h11);
    rd(asrx_pkg::OFF_RXDATA, 8'h22);
    tx(9'h044, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_PFLAGS, 8'h00);
    wr(asrx_pkg::OFF_RXSC, 8'h80);
    wr(asrx_pkg::OFF_RXSC, 8'h90);
    tx(9'h066, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_RXSC, 8'h90);
    rd(asrx_pkg::OFF_RXDATA, 8'h66);
    // nine-bit with address filtering, then without
    wr(asrx_pkg::OFF_RXSC, 8'hd8);
    tx(9'h017, 1'b1, 1'b1);
    rd(asrx_pkg::OFF_PFLAGS, 8'h00);
    tx(9'h142, 1'b1, 1'b1);
    rd(asrx_pkg::OFF_RXSC, 8'hd9);
    rd(asrx_pkg::OFF_RXDATA, 8'h42);
    wr(asrx_pkg::OFF_RXSC, 8'hd0);
    tx(9'h017, 1'b1, 1'b1);
    rd(asrx_pkg::OFF_RXSC, 8'hd0);
    rd(asrx_pkg::OFF_RXDATA, 8'h17);
    // low-speed range: a tick every four clocks, 64 clocks a bit; sync mode must block
    wr(asrx_pkg::OFF_RXSC, 8'h80);
    wr(asrx_pkg::OFF_BAUD, 8'h00);
    wr(asrx_pkg::OFF_TXSC, 8'h10);
    wr(asrx_pkg::OFF_RXSC, 8'h90);
    bit_clks = 64;
    tx(9'h0aa, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_PFLAGS, 8'h00);
    wr(asrx_pkg::OFF_TXSC, 8'h00);
    rd(asrx_pkg::OFF_TXSC, 8'h02);
    tx(9'h0c9, 1'b0, 1'b1);
    rd(asrx_pkg::OFF_RXDATA, 8'hc9);
    conclude();
  end
endmodule : tb_async_serial_receiver
